// ---- hdl/por_seq_pkg.sv ----
// Purpose: Constants and types for the power-on / watchdog reset sequencer
// Assumes: 10 MHz system clock, RC oscillators arrive as plain inputs
// Notes:   Timing counts are in RC oscillator periods unless named _CYCLES
// Contract
// - After power-up the core stays in reset for the power-on delay plus 18 clocks, then fetches from 000C hex.
// - The power-on delay lasts at least 12 ms and at most 100 ms.
// - The power-on delay is timed by its own RC oscillator, not by the system clock.
// - Power becoming good, stop-mode recovery, watchdog timeout or secondary watchdog timeout restart the delay.
// - The watchdog is a retriggerable one-shot that resets the whole device at terminal count.
// - The watchdog is idle until the first refresh instruction, and each later refresh restarts its count.
// - The watchdog counter is driven by an RC oscillator.
// - The watchdog timeout is at least 10 ms from the last restart.
// - The low 12 program bytes hold six 16-bit vectors, high byte first, so reset entry lies just above.
// - With the permanent-watchdog option the watchdog starts on leaving reset and runs in halt and stop.
package por_seq_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned SYS_CLK_HZ        = 10_000_000;
  localparam int unsigned RC_OSC_HZ         = 10_000;
  localparam int unsigned POR_MIN_MS        = 12;
  localparam int unsigned POR_MAX_MS        = 100;
  localparam int unsigned WDT_MIN_MS        = 10;
  localparam int unsigned POST_DELAY_CYCLES = 18;
  // Least times round up, plus one period: the first RC edge may follow a restart at once
  localparam int unsigned POR_TICKS = (POR_MIN_MS * RC_OSC_HZ + 999) / 1000 + 1;
  localparam int unsigned WDT_TICKS = (WDT_MIN_MS * RC_OSC_HZ + 999) / 1000 + 1;
  localparam int unsigned POR_TICKS_MAX = (POR_MAX_MS * RC_OSC_HZ) / 1000;

  // ==========================================================================
  // Program memory layout
  localparam int unsigned VECTOR_COUNT = 6;
  localparam int unsigned VECTOR_BYTES = 2;
  localparam logic [15:0] RESET_ENTRY  = 16'h000c;

  // ==========================================================================
  // Sequencer states, Gray along power-up path
  typedef enum logic [1:0] {
    ST_POR  = 2'b00,
    ST_POST = 2'b01,
    ST_RUN  = 2'b11
  } seq_state_t;

  // High byte of vector idx; low byte follows at +1
  function automatic logic [15:0] vector_addr(input int unsigned idx);
    vector_addr = 16'(idx * VECTOR_BYTES);
  endfunction : vector_addr

endpackage : por_seq_pkg

// ---- hdl/por_watchdog_reset_sequencer.sv ----
// Purpose: Power-on delay, watchdog and core reset release sequencing
// Assumes: RC oscillator and power-good pins are asynchronous to sys_clk_i
// Notes:   RC oscillator rate must stay well below sys_clk_i/4
module por_watchdog_reset_sequencer #(
  parameter int unsigned POR_TICKS_P = por_seq_pkg::POR_TICKS,
  parameter int unsigned WDT_TICKS_P = por_seq_pkg::WDT_TICKS,
  parameter int unsigned CNT_W       = 16
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        por_osc_i,
  input  wire logic        wdt_osc_i,
  input  wire logic        power_good_i,
  input  wire logic        secondary_watchdog_i,
  input  wire logic        stop_recovery_i,
  input  wire logic        watchdog_refresh_instruction_i,
  input  wire logic        halt_mode_i,
  input  wire logic        stop_mode_i,
  input  wire logic        perm_wdt_opt_i,
  output logic             core_rst_n_o,
  output logic             ctrl_reg_load_o,
  output logic             fetch_start_o,
  output logic [15:0]      fetch_addr_o,
  output logic             wdt_active_o,
  output logic             wdt_timeout_o,
  output por_seq_pkg::seq_state_t seq_state_o
);
  import por_seq_pkg::*;

  // ==========================================================================
  // Input synchronisers
  // Bits: 0 por osc, 1 wdt osc, 2 power good, 3 secondary watchdog
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  wire  [3:0] async_in = {secondary_watchdog_i, power_good_i, wdt_osc_i, por_osc_i};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  wire por_tick   = sync2_q[0] & ~sync3_q[0];
  wire wdt_tick   = sync2_q[1] & ~sync3_q[1];
  wire power_ok   = sync2_q[2];
  wire power_rise = sync2_q[2] & ~sync3_q[2];
  wire sec_rise   = sync2_q[3] & ~sync3_q[3];

  // ==========================================================================
  // Sequencer
  seq_state_t       state_q;
  seq_state_t       state_d;
  logic [CNT_W-1:0] por_cnt_q;
  logic [4:0]       post_cnt_q;
  logic             perm_q;
  logic             wdt_en_q;
  logic [CNT_W-1:0] wdt_cnt_q;

  wire por_done  = por_tick && (por_cnt_q == CNT_W'(POR_TICKS_P - 1));
  wire post_done = post_cnt_q == 5'(POST_DELAY_CYCLES - 1);
  wire wdt_run   = wdt_en_q && (perm_q || !(halt_mode_i || stop_mode_i));
  wire wdt_hit   = wdt_run && wdt_tick && (wdt_cnt_q == CNT_W'(WDT_TICKS_P - 1));
  // Any restart source sends the core back through the full delay
  wire restart   = power_rise || stop_recovery_i || wdt_hit || sec_rise;
  wire release_core = (state_q == ST_POST) && post_done;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POR:  if (por_done && power_ok) state_d = ST_POST;
      ST_POST: if (release_core) state_d = ST_RUN;
      ST_RUN:  state_d = ST_RUN;
      default: state_d = ST_POR;
    endcase
    if (restart || !power_ok) begin
      state_d = ST_POR;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  // Delay counts RC periods only, so sys clock drift cannot shorten it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_cnt_q <= '0;
    end else if (state_q != ST_POR || restart || !power_ok) begin
      por_cnt_q <= '0;
    end else if (por_tick && !por_done) begin
      por_cnt_q <= por_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      post_cnt_q <= 5'h00;
    end else if (state_q != ST_POST) begin
      post_cnt_q <= 5'h00;
    end else if (!post_done) begin
      post_cnt_q <= post_cnt_q + 5'h01;
    end
  end

  // Option strap caught while in ST_POR, not in ST_POST, never under reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      perm_q <= 1'b0;
    end else if (state_q == ST_POR) begin
      perm_q <= perm_wdt_opt_i;
    end
  end

  // ==========================================================================
  // Watchdog
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_en_q <= 1'b0;
    end else if (restart || state_q == ST_POR) begin
      wdt_en_q <= 1'b0;
    end else if (release_core && perm_q) begin
      wdt_en_q <= 1'b1;
    end else if (state_q == ST_RUN && watchdog_refresh_instruction_i) begin
      wdt_en_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_cnt_q <= '0;
    end else if (!wdt_en_q || restart || state_q == ST_POR || watchdog_refresh_instruction_i) begin
      wdt_cnt_q <= '0;
    end else if (wdt_run && wdt_tick) begin
      wdt_cnt_q <= wdt_cnt_q + CNT_W'(1);
    end
  end

  // ==========================================================================
  // Outputs
  logic fetch_q;
  logic timeout_q;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_q   <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      fetch_q   <= release_core && !restart && power_ok;
      timeout_q <= wdt_hit;
    end
  end

  assign core_rst_n_o    = (state_q == ST_RUN);
  assign ctrl_reg_load_o = (state_q != ST_RUN);
  assign fetch_start_o   = fetch_q;
  assign fetch_addr_o    = vector_addr(VECTOR_COUNT);
  assign wdt_active_o    = wdt_en_q;
  assign wdt_timeout_o   = timeout_q;
  assign seq_state_o     = state_q;

  // ==========================================================================
  // Checks
  chk_core_held: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (restart || !power_ok) |=> (!core_rst_n_o && ctrl_reg_load_o))
    else $error("core not held while sequencing");

  chk_por_max: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    por_cnt_q <= CNT_W'(POR_TICKS_P - 1))
    else $error("power-on delay overran its count");

  chk_post_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(core_rst_n_o) |-> ($past(post_cnt_q) == 5'd17) && $past(state_q) == ST_POST)
    else $error("core released without 18 post cycles");

  chk_fetch_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fetch_start_o |-> (fetch_addr_o == 16'h000c) && core_rst_n_o)
    else $error("fetch not at reset entry");

  chk_por_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == ST_POR ##1 state_q == ST_POST) |-> $past(por_cnt_q, 2) == CNT_W'(POR_TICKS_P - 1))
    else $error("power-on delay cut short");

  chk_por_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (stop_recovery_i || sec_rise || wdt_hit) |=> (state_q == ST_POR && por_cnt_q == '0))
    else $error("restart source did not restart delay");

  chk_wdt_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !wdt_en_q |-> wdt_cnt_q == '0)
    else $error("watchdog counting while idle");

  // Timeout pulse lands in the first cycle enable reads low, so also require enable low one cycle back
  chk_wdt_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!wdt_en_q && !$past(wdt_en_q)) |-> !wdt_timeout_o)
    else $error("timeout while watchdog idle");

  chk_wdt_pause: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wdt_en_q && !perm_q && halt_mode_i && state_q == ST_RUN && !restart
      && !watchdog_refresh_instruction_i) |=> $stable(wdt_cnt_q))
    else $error("watchdog counted in halt without option");

  chk_wdt_refresh: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (watchdog_refresh_instruction_i && state_q == ST_RUN && !restart && power_ok)
      |=> (wdt_en_q && wdt_cnt_q == '0))
    else $error("refresh did not restart watchdog");

  chk_wdt_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wdt_hit |=> (!core_rst_n_o && wdt_timeout_o) ##1 !wdt_timeout_o)
    else $error("watchdog timeout did not reset core");

  chk_perm_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (release_core && perm_q && !restart && power_ok) |=> wdt_en_q)
    else $error("permanent watchdog not started");

endmodule : por_watchdog_reset_sequencer

// ---- tb/core_partner.sv ----
// Purpose: Core model that issues watchdog refresh instructions
// Assumes: A refresh is a one-cycle pulse on sys_clk_i
// Notes:   Gap in cycles is set by the bench
module core_partner (
  input  wire logic       sys_clk_i,
  input  wire logic       core_rst_n_i,
  input  wire logic       run_i,
  input  wire logic [7:0] gap_i,
  output logic            refresh_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt  = 0;
  logic live = 1'b0;
  initial refresh_o = 1'b0;
  // A held core fetches nothing, so it cannot refresh
  // run_i and core_rst_n_i taken at the edge, before the bench moves them; gap_i is read 1 ns later
  always @(posedge sys_clk_i) begin
    live = run_i && core_rst_n_i;
    #1;
    cnt++;
    refresh_o = live && cnt > gap_i;
    if (refresh_o) cnt = 0;
  end
endmodule : core_partner

// ---- tb/tb_por_watchdog_reset_sequencer.sv ----
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Short counts POR 4 and watchdog 3 RC periods
// Notes:   RC oscillators free-run near 1 MHz, unrelated phases
module tb_por_watchdog_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import por_seq_pkg::*;
  localparam int unsigned PT = 4;
  // ==========================================================
  // Stimulus and observed signals
  logic        sys_clk_i = 0, rst_n_i = 0, por_osc = 0, wdt_osc = 0;
  logic        pgood = 0, sec_wd = 0, stop_rec = 0, halt = 0, stop = 0;
  logic        perm = 0, run = 0, refresh, core_rst_n, load, fstart, wact, wto;
  logic [7:0]  gap = 8'h08;
  logic [15:0] faddr;
  seq_state_t  state;
  int          err_total = 0, n_checks = 0, n_to = 0;
  por_watchdog_reset_sequencer #(.POR_TICKS_P(PT), .WDT_TICKS_P(3)) por_watchdog_reset_sequencer_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .por_osc_i(por_osc), .wdt_osc_i(wdt_osc),
    .power_good_i(pgood), .secondary_watchdog_i(sec_wd), .stop_recovery_i(stop_rec),
    .watchdog_refresh_instruction_i(refresh), .halt_mode_i(halt), .stop_mode_i(stop),
    .perm_wdt_opt_i(perm), .core_rst_n_o(core_rst_n), .ctrl_reg_load_o(load),
    .fetch_start_o(fstart), .fetch_addr_o(faddr), .wdt_active_o(wact),
    .wdt_timeout_o(wto), .seq_state_o(state));
  core_partner core_partner_i (.sys_clk_i(sys_clk_i), .core_rst_n_i(core_rst_n), .run_i(run),
    .gap_i(gap), .refresh_o(refresh));
  initial forever #50 sys_clk_i = ~sys_clk_i;
  initial forever #500 por_osc = ~por_osc;
  initial forever #470 wdt_osc = ~wdt_osc;
  always @(negedge sys_clk_i) if (wto === 1'b1) n_to++;
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic step(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask : step
  task automatic to_run();
    int d;
    int p;
    d = 0;
    p = 0;
    while (state !== ST_POST && d < 3000) begin step(1); d++; end
    while (state === ST_POST && p < 100) begin step(1); p++; end
    // A hung sequencer ends the run here
    if (d >= 3000 || p >= 100) begin
      err_total++;
      complete_run();
    end else begin
      chk("delay_len", 1, d >= (PT - 1) * 10 - 10 && d <= (PT + 2) * 10 + 10);
      chk("post_len", POST_DELAY_CYCLES, p);
      chk("core_run", 1, core_rst_n);
      chk("fetch", 1, fstart);
      chk("addr", RESET_ENTRY, faddr);
      chk("load", 0, load);
      $display("release done");
    end
  endtask : to_run
  task automatic wait_to(input int lo, input int hi);
    int c;
    c = 0;
    while (wto !== 1'b1 && c < 300) begin step(1); c++; end
    if (c >= 300) begin
      err_total++;
      complete_run();
    end else begin
      chk("to_gap", 1, c >= lo && c <= hi);
      chk("to_held", 0, core_rst_n);
      $display("timeout done");
    end
  endtask : wait_to
  initial begin
    void'($urandom(69966));
    step(3);
    rst_n_i = 1;
    step(20 + $urandom % 20);
    chk("held", 0, core_rst_n);
    chk("held_load", 1, load);
    pgood = 1;
    to_run();
    step(60);
    chk("wd_idle", 0, wact);
    gap = 8'(4 + $urandom % 9);
    run = 1;
    step(200);
    chk("wd_on", 1, wact);
    chk("no_to", 0, n_to);
    // Refreshes go on into halt so the frozen count starts from zero
    halt = 1;
    step(20);
    run = 0;
    step(60);
    chk("halt_hold", 0, n_to);
    chk("halt_on", 1, wact);
    halt = 0;
    wait_to(17, 60);
    to_run();
    for (int k = 0; k < 3; k++) begin
      stop_rec = k == 0;
      sec_wd = k == 1;
      pgood = k != 2;
      step(1);
      stop_rec = 0;
      pgood = 1;
      step(4);
      chk("restart", ST_POR, state);
      sec_wd = 0;
      to_run();
    end
    perm = 1;
    stop_rec = 1;
    step(1);
    stop_rec = 0;
    to_run();
    step(1);
    chk("perm_on", 1, wact);
    halt = 1;
    stop = 1;
    wait_to(17, 60);
    complete_run();
  end
endmodule : tb_por_watchdog_reset_sequencer
